// ==== snp_pkg.sv ====
// Package with the constants, types and register map of the serial packer.
package snp_pkg;

  // Register offsets.
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_DELIM    = 8'h04;
  localparam logic [7:0]  ADDR_TMO      = 8'h08;
  localparam logic [7:0]  ADDR_PORT     = 8'h0C;
  localparam logic [7:0]  ADDR_STAT     = 8'h10;

  // Field positions.
  localparam int          CTRL_LEN_LSB  = 0;
  localparam int          CTRL_PROC_LSB = 12;
  localparam int          CTRL_CONN_LSB = 16;
  localparam int          DELIM1_LSB    = 0;
  localparam int          DELIM2_LSB    = 8;
  localparam int          TMO_FORCE_LSB = 0;
  localparam int          TMO_INACT_LSB = 16;
  localparam int          PORT_LSB      = 0;
  localparam int          STAT_SES_BIT  = 0;
  localparam int          STAT_BUSY_BIT = 1;
  localparam int          STAT_CNT_LSB  = 16;

  // Widths and sizes.
  localparam int          CNT_W         = 11;
  localparam int          BUF_DEPTH     = 1024;

  // Reset values.
  localparam logic [10:0] RST_PKT_LEN   = 11'h000;
  localparam logic [7:0]  RST_DELIM     = 8'h00;
  localparam logic [15:0] RST_FORCE     = 16'h0000;
  localparam logic [15:0] RST_INACT     = 16'h0000;
  localparam logic [15:0] RST_PORT      = 16'h0FA1;

  // Timing.
  localparam int          MS_NS         = 1000000;
  localparam int          CLK_NS        = 5;
  localparam int          CYC_PER_MS    = MS_NS / CLK_NS;

  typedef enum logic [1:0] {PROC_NONE, PROC_PLUS1, PROC_PLUS2, PROC_STRIP} snp_proc_e;

  typedef enum logic [2:0] {
    CONN_STARTUP, CONN_ANY_NONE, CONN_ANY_INACT,
    CONN_DSR_OFF, CONN_DSR_NONE, CONN_DCD_OFF, CONN_DCD_NONE
  } snp_conn_e;

  typedef enum logic [1:0] {DR_IDLE, DR_LOAD, DR_SEND} snp_drain_e;

  typedef struct packed {
    logic [10:0] pkt_len;
    snp_proc_e   proc;
    snp_conn_e   conn;
    logic [7:0]  d1;
    logic [7:0]  d2;
    logic [15:0] force_ms;
    logic [15:0] inact_ms;
    logic [15:0] port;
  } snp_cfg_s;

endpackage : snp_pkg

// ==== snp_packer.sv ====
// Serial to network packer with APB configuration and session control.
// Contract
// - Packet length zero means no length limit on frames.
// - Packet length 1 to 1024 releases frame when count reaches it.
// - No delimiter configured forwards each byte at once.
// - With a delimiter, bytes accumulate until the delimiter sequence completes.
// - Delimiter values of zero are unused; second alone gives no delimiting.
// - A full buffer is released as a frame and emptied.
// - Idle timeout 1 to 65535 ms releases buffered data as one frame.
// - Idle timeout zero disables the idle timer.
// - Delimiter handling needs first delimiter; two-char waits for both.
// - Plain option releases data including delimiter on receipt.
// - Plus-one or plus-two waits for that many bytes after delimiter.
// - Strip option drops delimiter characters and releases the rest.
// - Startup option opens the session at start and never closes.
// - Any-character options open on first byte, optionally close on inactivity.
// - DSR options open on DSR high, optionally close on DSR low.
// - DCD options open on DCD high, optionally close on DCD low.
// - Local listen port is configurable 1 to 65535, default 4001.
// - Inactivity timer restarts on every serial byte in either direction.
// - Inactivity time zero keeps the session open until a close request.
module snp_packer #(
  parameter int DEPTH      = snp_pkg::BUF_DEPTH,
  parameter int CYC_PER_MS = snp_pkg::CYC_PER_MS
) (
  // Clock, reset and enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Serial receive stream.
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_data,
  output logic             rx_ready,
  input  wire logic        tx_activity,
  // Modem control pins.
  input  wire logic        dsr,
  input  wire logic        dcd,
  // Frame output to the network stack.
  output logic             out_valid,
  output logic      [7:0]  out_data,
  output logic             out_last,
  input  wire logic        out_ready,
  // Session control.
  input  wire logic        close_req,
  output logic             session_open,
  output logic      [15:0] local_port
);

  localparam int IW = $clog2(DEPTH);
  localparam int PW = $clog2(CYC_PER_MS + 1);
  localparam logic [10:0] DEPTH_C = 11'(DEPTH);
  localparam logic [PW-1:0] PRE_MAX = PW'(CYC_PER_MS - 1);

  if (DEPTH < 2 || DEPTH > snp_pkg::BUF_DEPTH || (1 << IW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two from 2 to 1024");
  end
  if (CYC_PER_MS < 1) begin : g_bad_rate
    $error("CYC_PER_MS must be at least one");
  end

  snp_pkg::snp_cfg_s   cfg, next_cfg;
  logic [31:0]         next_prdata;
  logic [7:0]          mem [DEPTH];
  logic [10:0]         count, next_count, nc;
  logic [1:0]          post, next_post;
  logic                prev_d1, next_prev_d1;
  logic [15:0]         idle_ms, next_idle_ms;
  logic [15:0]         inact_ms, next_inact_ms;
  logic [PW-1:0]       pre, next_pre;
  logic                tick;
  logic                acc, flush, wr_en;
  logic                dlm_on, two, hit1, hit2, delim_hit, strip;
  snp_pkg::snp_drain_e state, next_state;
  logic [IW-1:0]       rd_idx, next_rd_idx;
  logic [10:0]         frame_len, next_frame_len;
  logic [7:0]          next_out_data;
  logic                next_out_last;
  logic                next_session;
  logic                inact_fire, open_c, close_c;
  logic [1:0]          dsr_sync, dcd_sync;
  logic                dsr_s, dcd_s;
  logic                wr_cyc, rd_cyc, mapped;

  // Modem control pins are synchronised before use.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dsr_sync <= 2'h0;
      dcd_sync <= 2'h0;
    end else if (ce) begin
      dsr_sync <= {dsr_sync[0], dsr};
      dcd_sync <= {dcd_sync[0], dcd};
    end
  end
  assign dsr_s = dsr_sync[1];
  assign dcd_s = dcd_sync[1];

  // APB slave with zero wait states; read data is captured in the setup cycle.
  assign pready = 1'b1;
  assign mapped = paddr inside {snp_pkg::ADDR_CTRL, snp_pkg::ADDR_DELIM, snp_pkg::ADDR_TMO,
                                snp_pkg::ADDR_PORT, snp_pkg::ADDR_STAT};
  assign pslverr = psel && penable && !mapped;
  assign wr_cyc = psel && penable && pwrite && mapped;
  assign rd_cyc = psel && !penable && !pwrite;

  always_comb begin
    next_cfg = cfg;
    next_prdata = prdata;
    if (wr_cyc) begin
      case (paddr)
        snp_pkg::ADDR_CTRL: begin
          next_cfg.pkt_len = pwdata[snp_pkg::CTRL_LEN_LSB +: 11];
          next_cfg.proc = snp_pkg::snp_proc_e'(pwdata[snp_pkg::CTRL_PROC_LSB +: 2]);
          next_cfg.conn = snp_pkg::snp_conn_e'(pwdata[snp_pkg::CTRL_CONN_LSB +: 3]);
        end
        snp_pkg::ADDR_DELIM: begin
          next_cfg.d1 = pwdata[snp_pkg::DELIM1_LSB +: 8];
          next_cfg.d2 = pwdata[snp_pkg::DELIM2_LSB +: 8];
        end
        snp_pkg::ADDR_TMO: begin
          next_cfg.force_ms = pwdata[snp_pkg::TMO_FORCE_LSB +: 16];
          next_cfg.inact_ms = pwdata[snp_pkg::TMO_INACT_LSB +: 16];
        end
        snp_pkg::ADDR_PORT: begin
          if (pwdata[snp_pkg::PORT_LSB +: 16] != 16'h0000) begin
            next_cfg.port = pwdata[snp_pkg::PORT_LSB +: 16];
          end
        end
        default: begin
        end
      endcase
    end
    if (rd_cyc) begin
      next_prdata = 32'h0000_0000;
      case (paddr)
        snp_pkg::ADDR_CTRL: begin
          next_prdata[snp_pkg::CTRL_LEN_LSB +: 11] = cfg.pkt_len;
          next_prdata[snp_pkg::CTRL_PROC_LSB +: 2] = cfg.proc;
          next_prdata[snp_pkg::CTRL_CONN_LSB +: 3] = cfg.conn;
        end
        snp_pkg::ADDR_DELIM: begin
          next_prdata[snp_pkg::DELIM1_LSB +: 8] = cfg.d1;
          next_prdata[snp_pkg::DELIM2_LSB +: 8] = cfg.d2;
        end
        snp_pkg::ADDR_TMO: begin
          next_prdata[snp_pkg::TMO_FORCE_LSB +: 16] = cfg.force_ms;
          next_prdata[snp_pkg::TMO_INACT_LSB +: 16] = cfg.inact_ms;
        end
        snp_pkg::ADDR_PORT: begin
          next_prdata[snp_pkg::PORT_LSB +: 16] = cfg.port;
        end
        snp_pkg::ADDR_STAT: begin
          next_prdata[snp_pkg::STAT_SES_BIT] = session_open;
          next_prdata[snp_pkg::STAT_BUSY_BIT] = (state != snp_pkg::DR_IDLE);
          next_prdata[snp_pkg::STAT_CNT_LSB +: 11] = count;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg <= '{snp_pkg::RST_PKT_LEN, snp_pkg::PROC_NONE, snp_pkg::CONN_STARTUP,
               snp_pkg::RST_DELIM, snp_pkg::RST_DELIM, snp_pkg::RST_FORCE,
               snp_pkg::RST_INACT, snp_pkg::RST_PORT};
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      cfg <= next_cfg;
      prdata <= next_prdata;
    end
  end
  assign local_port = cfg.port;

  // Millisecond time base.
  assign tick = (pre == PRE_MAX);
  assign next_pre = tick ? '0 : PW'(pre + 1'b1);

  // Packing: delimiter detection, length, full and idle release.
  assign rx_ready = (state == snp_pkg::DR_IDLE);
  assign acc = rx_valid && rx_ready && ce;
  assign dlm_on = (cfg.d1 != 8'h00);
  assign two = dlm_on && (cfg.d2 != 8'h00);

  always_comb begin
    next_count = count;
    next_post = post;
    next_prev_d1 = prev_d1;
    next_idle_ms = idle_ms;
    nc = count;
    flush = 1'b0;
    wr_en = 1'b0;
    hit1 = 1'b0;
    hit2 = 1'b0;
    delim_hit = 1'b0;
    strip = 1'b0;
    if (acc) begin
      next_idle_ms = 16'h0000;
      if (post != 2'h0) begin
        wr_en = 1'b1;
        nc = 11'(count + 1'b1);
        next_post = 2'(post - 1'b1);
        flush = (post == 2'h1);
      end else begin
        hit1 = dlm_on && !two && (rx_data == cfg.d1);
        hit2 = two && prev_d1 && (rx_data == cfg.d2);
        delim_hit = hit1 || hit2;
        strip = delim_hit && (cfg.proc == snp_pkg::PROC_STRIP);
        if (hit2 && strip) begin
          nc = 11'(count - 1'b1);
        end else if (!(hit1 && strip)) begin
          wr_en = 1'b1;
          nc = 11'(count + 1'b1);
        end
        next_prev_d1 = two && (rx_data == cfg.d1);
        if (delim_hit) begin
          case (cfg.proc)
            snp_pkg::PROC_PLUS1: next_post = 2'h1;
            snp_pkg::PROC_PLUS2: next_post = 2'h2;
            default: flush = 1'b1;
          endcase
        end
        if (!dlm_on) begin
          flush = 1'b1;
        end
      end
      if (cfg.pkt_len != 11'h000 && nc >= cfg.pkt_len) begin
        flush = 1'b1;
      end
      if (nc == DEPTH_C) begin
        flush = 1'b1;
      end
    end else if (ce && tick && count != 11'h000 && cfg.force_ms != 16'h0000 && rx_ready) begin
      if (17'(idle_ms) + 17'h00001 >= 17'(cfg.force_ms)) begin
        flush = 1'b1;
        next_idle_ms = 16'h0000;
      end else begin
        next_idle_ms = 16'(idle_ms + 1'b1);
      end
    end
    if (flush) begin
      next_count = 11'h000;
      next_post = 2'h0;
      next_prev_d1 = 1'b0;
      next_idle_ms = 16'h0000;
    end else begin
      next_count = nc;
    end
  end

  // Frame drain: load a byte, offer it, advance on acceptance.
  always_comb begin
    next_state = state;
    next_rd_idx = rd_idx;
    next_frame_len = frame_len;
    next_out_data = out_data;
    next_out_last = out_last;
    case (state)
      snp_pkg::DR_IDLE: begin
        if (flush && nc != 11'h000) begin
          next_state = snp_pkg::DR_LOAD;
          next_rd_idx = '0;
          next_frame_len = nc;
        end
      end
      snp_pkg::DR_LOAD: begin
        next_out_data = mem[rd_idx];
        next_out_last = (11'(rd_idx) == 11'(frame_len - 1'b1));
        next_state = snp_pkg::DR_SEND;
      end
      snp_pkg::DR_SEND: begin
        if (out_ready) begin
          next_state = out_last ? snp_pkg::DR_IDLE : snp_pkg::DR_LOAD;
          next_rd_idx = IW'(rd_idx + 1'b1);
        end
      end
      default: next_state = snp_pkg::DR_IDLE;
    endcase
  end
  assign out_valid = (state == snp_pkg::DR_SEND);

  always_ff @(posedge pclk) begin
    if (acc && wr_en) begin
      mem[count[IW-1:0]] <= rx_data;
    end
  end

  // Session control with inactivity timer.
  always_comb begin
    next_session = session_open;
    next_inact_ms = inact_ms;
    open_c = 1'b0;
    inact_fire = 1'b0;
    if (acc || tx_activity) begin
      next_inact_ms = 16'h0000;
    end else if (tick && session_open && cfg.conn == snp_pkg::CONN_ANY_INACT
                 && cfg.inact_ms != 16'h0000) begin
      next_inact_ms = 16'(inact_ms + 1'b1);
      inact_fire = (17'(inact_ms) + 17'h00001 >= 17'(cfg.inact_ms));
    end
    close_c = close_req || inact_fire;
    case (cfg.conn)
      snp_pkg::CONN_STARTUP: begin
        open_c = 1'b1;
        close_c = 1'b0;
      end
      snp_pkg::CONN_ANY_NONE, snp_pkg::CONN_ANY_INACT: open_c = acc;
      snp_pkg::CONN_DSR_OFF: begin
        open_c = dsr_s;
        close_c = close_c || !dsr_s;
      end
      snp_pkg::CONN_DSR_NONE: open_c = dsr_s;
      snp_pkg::CONN_DCD_OFF: begin
        open_c = dcd_s;
        close_c = close_c || !dcd_s;
      end
      snp_pkg::CONN_DCD_NONE: open_c = dcd_s;
      default: open_c = 1'b0;
    endcase
    if (open_c) begin
      next_session = 1'b1;
    end else if (close_c) begin
      next_session = 1'b0;
    end
    if (!session_open) begin
      next_inact_ms = 16'h0000;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre <= '0;
      count <= 11'h000;
      post <= 2'h0;
      prev_d1 <= 1'b0;
      idle_ms <= 16'h0000;
      inact_ms <= 16'h0000;
      state <= snp_pkg::DR_IDLE;
      rd_idx <= '0;
      frame_len <= 11'h000;
      out_data <= 8'h00;
      out_last <= 1'b0;
      session_open <= 1'b0;
    end else if (ce) begin
      pre <= next_pre;
      count <= next_count;
      post <= next_post;
      prev_d1 <= next_prev_d1;
      idle_ms <= next_idle_ms;
      inact_ms <= next_inact_ms;
      state <= next_state;
      rd_idx <= next_rd_idx;
      frame_len <= next_frame_len;
      out_data <= next_out_data;
      out_last <= next_out_last;
      session_open <= next_session;
    end
  end

  // Checks on the packing and session behaviour.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_no_delim;
    (acc && cfg.d1 == 8'h00 && count == 11'h000) |=> (frame_len == 11'h001) ##1 out_valid;
  endproperty
  a_no_delim: assert property (p_no_delim) else $error("byte not forwarded");

  property p_len;
    (acc && cfg.pkt_len != 11'h000 && nc == cfg.pkt_len) |=> (count == 11'h000) ##1 out_valid;
  endproperty
  a_len: assert property (p_len) else $error("length limit missed");

  property p_full;
    (acc && nc == DEPTH_C) |=> (frame_len == DEPTH_C && count == 11'h000);
  endproperty
  a_full: assert property (p_full) else $error("full buffer not released");

  property p_strip;
    (acc && hit1 && cfg.proc == snp_pkg::PROC_STRIP && count != 11'h000)
      |=> (frame_len == $past(count));
  endproperty
  a_strip: assert property (p_strip) else $error("delimiter not stripped");

  property p_plus2;
    (acc && delim_hit && cfg.proc == snp_pkg::PROC_PLUS2 && nc != DEPTH_C
     && (cfg.pkt_len == 11'h000 || nc < cfg.pkt_len))
      |=> (post == 2'h2 && state == snp_pkg::DR_IDLE);
  endproperty
  a_plus2: assert property (p_plus2) else $error("plus two released early");

  property p_force0;
    (ce && cfg.force_ms == 16'h0000 && !acc && state == snp_pkg::DR_IDLE) |=> !out_valid;
  endproperty
  a_force0: assert property (p_force0) else $error("release with timer off");

  property p_startup;
    (ce && cfg.conn == snp_pkg::CONN_STARTUP) |=> session_open;
  endproperty
  a_startup: assert property (p_startup) else $error("startup session closed");

  property p_dsr_off;
    (ce && cfg.conn == snp_pkg::CONN_DSR_OFF && !dsr_s) |=> !session_open;
  endproperty
  a_dsr_off: assert property (p_dsr_off) else $error("session open with DSR low");

  property p_inact0;
    (ce && cfg.conn == snp_pkg::CONN_ANY_INACT && cfg.inact_ms == 16'h0000
     && session_open && !close_req) |=> session_open;
  endproperty
  a_inact0: assert property (p_inact0) else $error("session closed with timer off");

  property p_one_frame;
    (out_valid && out_ready && out_last && ce) |=> !out_valid;
  endproperty
  a_one_frame: assert property (p_one_frame) else $error("frame end not honoured");

  c_frame_end: cover property (out_valid && out_ready && out_last);
  c_strip: cover property (acc && strip);
  c_dcd_open: cover property (cfg.conn == snp_pkg::CONN_DCD_OFF && $rose(session_open));
  c_idle: cover property (flush && !acc);

endmodule : snp_packer

// ==== snp_net_model.sv ====
// Network side model that takes frame bytes, promptly or with random stalls.
module snp_net_model (
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Frame stream from the packer.
  input  wire logic       out_valid,
  input  wire logic [7:0] out_data,
  input  wire logic       out_last,
  output logic            out_ready,
  // Stall control.
  input  wire logic       slow
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [8:0] got_q[$];

  // A byte is taken at the rising edge at which valid and ready are both high.
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_ready <= 1'b0;
    end else begin
      if (out_valid === 1'b1 && out_ready) begin
        got_q.push_back({out_last, out_data});
      end
      out_ready <= !slow || ($urandom_range(2) == 0);
    end
  end
endmodule : snp_net_model

// ==== tb_serial_to_network_packer.sv ====
// Testbench for the serial packer with a byte level reference model.
module tb_serial_to_network_packer;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int DEP = 16;
  localparam int CPM = 10;

  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        ce = 1'b1;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        rx_valid = 1'b0;
  logic [7:0]  rx_data = 8'h00;
  logic        rx_ready;
  logic        tx_activity = 1'b0;
  logic        dsr = 1'b0;
  logic        dcd = 1'b0;
  logic        out_valid;
  logic [7:0]  out_data;
  logic        out_last;
  logic        out_ready;
  logic        close_req = 1'b0;
  logic        session_open;
  logic [15:0] local_port;
  logic        slow = 1'b0;
  logic [31:0] rd;
  logic        err;
  int          n_fail = 0;
  int          n_checks = 0;
  int          cyc = 0;
  int          exp_q[$];
  int          buf_q[$];
  int          m_len, m_proc, m_d1, m_d2, tail, prev;
  int          lens[3] = '{1, 3, 4};

  always #2.5 pclk = ~pclk;

  snp_packer #(.DEPTH(DEP), .CYC_PER_MS(CPM)) u_dut (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .rx_valid(rx_valid), .rx_data(rx_data), .rx_ready(rx_ready),
    .tx_activity(tx_activity), .dsr(dsr), .dcd(dcd), .out_valid(out_valid),
    .out_data(out_data), .out_last(out_last), .out_ready(out_ready),
    .close_req(close_req), .session_open(session_open), .local_port(local_port));

  snp_net_model u_net (
    .pclk(pclk), .presetn(presetn), .out_valid(out_valid), .out_data(out_data),
    .out_last(out_last), .out_ready(out_ready), .slow(slow));

  task automatic close_out();
    $display("Checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_fail++;
      close_out();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wt(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : wt

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cfg(input int len, pr, cn, d1, d2, frc, ina);
    m_len = len;
    m_proc = pr;
    m_d1 = d1;
    m_d2 = d2;
    tail = 0;
    prev = 0;
    apb(1'b1, snp_pkg::ADDR_CTRL, 32'(len | (pr << 12) | (cn << 16)));
    apb(1'b1, snp_pkg::ADDR_DELIM, 32'(d1 | (d2 << 8)));
    apb(1'b1, snp_pkg::ADDR_TMO, 32'(frc | (ina << 16)));
  endtask : cfg

  task automatic rel();
    foreach (buf_q[i]) exp_q.push_back(buf_q[i] | (i == buf_q.size() - 1 ? 256 : 0));
    buf_q.delete();
    tail = 0;
  endtask : rel

  task automatic send(input int b);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_data <= 8'(b);
    @(posedge pclk);
    while (rx_ready !== 1'b1) @(posedge pclk);
    rx_valid <= 1'b0;
    buf_q.push_back(b);
    if (m_d1 == 0) begin
      rel();
    end else if (tail > 0) begin
      tail--;
      if (tail == 0) rel();
    end else if (m_d2 == 0 ? b == m_d1 : (b == m_d2 && prev == m_d1)) begin
      if (m_proc == 0) rel();
      else if (m_proc == 3) begin
        repeat (m_d2 == 0 ? 1 : 2) void'(buf_q.pop_back());
        if (buf_q.size() > 0) rel();
      end else tail = m_proc;
    end
    if (m_len != 0 && buf_q.size() >= m_len) rel();
    if (buf_q.size() == DEP) rel();
    prev = b;
  endtask : send

  function automatic int rb();
    return $urandom_range(8'h7E, 8'h20);
  endfunction : rb

  task automatic drain();
    int i;
    i = 0;
    while (u_net.got_q.size() < exp_q.size() && i < 3000) begin
      @(posedge pclk);
      i++;
    end
    wt(4);
    check(32'(u_net.got_q.size()), 32'(exp_q.size()));
    foreach (exp_q[k]) if (k < u_net.got_q.size()) check(u_net.got_q[k], exp_q[k]);
    u_net.got_q.delete();
    exp_q.delete();
  endtask : drain

  task automatic pulse(input logic tx);
    @(posedge pclk);
    if (tx) tx_activity <= 1'b1;
    else close_req <= 1'b1;
    @(posedge pclk);
    tx_activity <= 1'b0;
    close_req <= 1'b0;
    wt(3);
  endtask : pulse

  initial begin
    void'($urandom(73));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    wt(2);
    check(32'(local_port), 32'h0000_0FA1);
    check(32'(session_open), 32'h1);
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 8'(4 * k), 32'h0);
      check(rd, k == 3 ? 32'h0000_0FA1 : 32'h0);
    end
    apb(1'b0, 8'h14, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, snp_pkg::ADDR_PORT, 32'h0000_FFFF);
    apb(1'b1, snp_pkg::ADDR_PORT, 32'h0);
    check(32'(local_port), 32'h0000_FFFF);
    pulse(1'b0);
    check(32'(session_open), 32'h1);
    cfg(0, 0, 0, 0, 8'h0A, 0, 0);
    repeat (3) send(rb());
    send(8'h0A);
    drain();
    slow <= 1'b1;
    for (int pr = 0; pr < 4; pr++) begin
      for (int t = 0; t < 2; t++) begin
        cfg(0, pr, 0, 8'h0D, t ? 8'h0A : 8'h00, 0, 0);
        send(rb());
        send(rb());
        send(8'h0D);
        if (t) send(8'h0A);
        repeat (pr == 1 || pr == 2 ? pr : 0) send(rb());
        drain();
      end
    end
    foreach (lens[j]) begin
      cfg(lens[j], 0, 0, 8'h0D, 0, 0, 0);
      send(rb());
      send(rb());
      send(8'h0D);
      drain();
    end
    cfg(0, 0, 0, 8'h0D, 0, 0, 0);
    repeat (DEP + 2) send(rb());
    send(8'h0D);
    drain();
    slow <= 1'b0;
    cfg(0, 0, 0, 8'h0D, 0, 2, 0);
    send(rb());
    send(rb());
    wt(8);
    check(32'(u_net.got_q.size()), 32'h0);
    @(posedge pclk);
    ce <= 1'b0;
    wt(40);
    check(32'(u_net.got_q.size()), 32'h0);
    @(posedge pclk);
    ce <= 1'b1;
    rel();
    drain();
    cfg(0, 0, 0, 8'h0D, 0, 0, 0);
    send(rb());
    wt(200);
    check(32'(u_net.got_q.size()), 32'h0);
    apb(1'b0, snp_pkg::ADDR_STAT, 32'h0);
    check(rd, 32'((1 << snp_pkg::STAT_CNT_LSB) | (1 << snp_pkg::STAT_SES_BIT)));
    send(8'h0D);
    drain();
    cfg(0, 0, 1, 0, 0, 0, 0);
    pulse(1'b0);
    check(32'(session_open), 32'h0);
    send(rb());
    wt(100);
    check(32'(session_open), 32'h1);
    cfg(0, 0, 2, 0, 0, 0, 3);
    pulse(1'b0);
    send(rb());
    repeat (6) begin
      wt(15);
      pulse(1'b1);
    end
    check(32'(session_open), 32'h1);
    wt(60);
    check(32'(session_open), 32'h0);
    cfg(0, 0, 2, 0, 0, 0, 0);
    send(rb());
    wt(100);
    check(32'(session_open), 32'h1);
    pulse(1'b0);
    check(32'(session_open), 32'h0);
    drain();
    for (int m = 3; m < 7; m++) begin
      cfg(0, 0, m, 0, 0, 0, 0);
      pulse(1'b0);
      @(posedge pclk);
      dsr <= (m < 5);
      dcd <= (m > 4);
      wt(6);
      check(32'(session_open), 32'h1);
      @(posedge pclk);
      dsr <= 1'b0;
      dcd <= 1'b0;
      wt(6);
      check(32'(session_open), 32'((m == 4) || (m == 6)));
    end
    close_out();
  end
endmodule : tb_serial_to_network_packer
